/* hdl/ec_monitor_defs.svh */
// register indices, reset values and field positions of the canceller monitor group
`ifndef EC_MONITOR_DEFS_SVH
`define EC_MONITOR_DEFS_SVH

// ----------------------------------------------------------------------
// register indices (byte address on apb is four times the index)
// ----------------------------------------------------------------------
`define EC_IDX_W                     6
`define EC_IDX_SEND_PEAK_LOW_A       6'h0e
`define EC_IDX_SEND_PEAK_HIGH_A      6'h0f
`define EC_IDX_ERROR_PEAK_LOW_A      6'h10
`define EC_IDX_ERROR_PEAK_HIGH_A     6'h11
`define EC_IDX_PATH_CHANGE_TIMER_A   6'h12
`define EC_IDX_PATH_CHANGE_SENS_A    6'h13
`define EC_IDX_DT_THRESHOLD_LOW_A    6'h14
`define EC_IDX_DT_THRESHOLD_HIGH_A   6'h15
`define EC_IDX_SEND_PEAK_LOW_B       6'h2e
`define EC_IDX_SEND_PEAK_HIGH_B      6'h2f
`define EC_IDX_ERROR_PEAK_LOW_B      6'h20
`define EC_IDX_ERROR_PEAK_HIGH_B     6'h21
`define EC_IDX_PATH_CHANGE_TIMER_B   6'h32
`define EC_IDX_PATH_CHANGE_SENS_B    6'h33
`define EC_IDX_DT_THRESHOLD_LOW_B    6'h34
`define EC_IDX_DT_THRESHOLD_HIGH_B   6'h35

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define EC_RST_PATH_CHANGE_TIMER     8'h10
`define EC_RST_PATH_CHANGE_SENS      8'h41
`define EC_RST_DT_THRESHOLD_LOW      8'h00
`define EC_RST_DT_THRESHOLD_HIGH     8'h48

// ----------------------------------------------------------------------
// field positions and limits
// ----------------------------------------------------------------------
`define EC_DT_SIGN_BIT               7
`define EC_PEAK_MAX                  16'h7fff
`define EC_PEAK_MIN                  16'h8000

`endif

/* hdl/ec_monitor_pkg.sv */
// types shared by the canceller monitor register group
`default_nettype none
package ec_monitor_pkg;

   // register field selected by an apb index
   typedef enum logic [3:0] {
      FLD_NONE      = 4'h0,
      FLD_SPEAK_LO  = 4'h1,
      FLD_SPEAK_HI  = 4'h2,
      FLD_EPEAK_LO  = 4'h3,
      FLD_EPEAK_HI  = 4'h4,
      FLD_TIMER     = 4'h5,
      FLD_SENS      = 4'h6,
      FLD_DT_LO     = 4'h7,
      FLD_DT_HI     = 4'h8
   } reg_field_t;

   // decoded register hit: canceller and field
   typedef struct packed {
      logic       chan;
      reg_field_t field;
   } reg_hit_t;

   // path change detector states, one-hot
   typedef enum logic [2:0] {
      PC_WATCH    = 3'b001,
      PC_COUNT    = 3'b010,
      PC_DECLARED = 3'b100
   } path_state_t;

endpackage
`default_nettype wire

/* hdl/peak_tracker.sv */
// magnitude peak tracker for one 16-bit two's complement sample stream
`timescale 1ns/1ps
`default_nettype none
`include "ec_monitor_defs.svh"

module peak_tracker #(
   parameter int W = 16
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         sample_valid,
   input  wire logic [W-1:0] sample,
   input  wire logic         restart,
   output logic      [W-1:0] peak
);

   logic [W-1:0] mag;
   logic [W-1:0] peak_q;

   // magnitude, most negative code saturates to full scale
   always_comb begin
      if (sample == W'(`EC_PEAK_MIN))
         mag = W'(`EC_PEAK_MAX);
      else if (sample[W-1])
         mag = W'(~sample + W'(1));
      else
         mag = sample;
   end

   // hold the largest magnitude since the last restart
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         peak_q <= '0;
      else if (restart)
         peak_q <= sample_valid ? mag : '0;
      else if (sample_valid && (mag > peak_q))
         peak_q <= mag;
   end

   assign peak = peak_q;

   a_peak_monotonic: assert property (@(posedge pclk) disable iff (!presetn)
      !$past(restart) |-> peak_q >= $past(peak_q))
      else $error("peak fell without a restart");

   a_peak_positive: assert property (@(posedge pclk) disable iff (!presetn)
      !peak_q[W-1])
      else $error("peak magnitude has sign bit set");

endmodule
`default_nettype wire

/* hdl/ec_monitor_regs.sv */
// per-canceller monitor and tuning register group with path change detectors
//
// Functional notes
// - send-in peak level captured continuously per canceller, 16-bit two's complement
// - peak value high byte in second register, low byte in first
// - error signal peak tracked per canceller, read from two 8-bit read-only registers
// - path change declared after negative enhancement lasts the programmed timer, reset 10h
// - larger timer value needs longer negative enhancement before declaring
// - double-talk threshold 16-bit read-write, high byte resets 48h, low 00h
// - double-talk threshold is high-level detection limit, maximum 7fffh
`timescale 1ns/1ps
`default_nettype none
`include "ec_monitor_defs.svh"

module ec_monitor_regs
   import ec_monitor_pkg::*;
#(
   parameter int AW = 8
) (
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [AW-1:0] paddr,
   input  wire logic [31:0]   pwdata,
   output logic      [31:0]   prdata,
   output logic               pready,
   output logic               pslverr,
   input  wire logic          sample_valid,
   input  wire logic [15:0]   send_in_a,
   input  wire logic [15:0]   send_in_b,
   input  wire logic [15:0]   error_a,
   input  wire logic [15:0]   error_b,
   input  wire logic          measure_tick,
   input  wire logic [7:0]    echo_loss_enhancement_deficit_a,
   input  wire logic [7:0]    echo_loss_enhancement_deficit_b,
   output logic      [15:0]   dt_threshold_a,
   output logic      [15:0]   dt_threshold_b,
   output logic               path_change_a,
   output logic               path_change_b
);

   // ----------------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------------

   // map a word index to canceller and field
   function automatic reg_hit_t decode_idx(input logic [`EC_IDX_W-1:0] idx);
      reg_hit_t h;
      h.chan  = 1'b0;
      h.field = FLD_NONE;
      unique case (idx)
         `EC_IDX_SEND_PEAK_LOW_A:     h = '{1'b0, FLD_SPEAK_LO};
         `EC_IDX_SEND_PEAK_HIGH_A:    h = '{1'b0, FLD_SPEAK_HI};
         `EC_IDX_ERROR_PEAK_LOW_A:    h = '{1'b0, FLD_EPEAK_LO};
         `EC_IDX_ERROR_PEAK_HIGH_A:   h = '{1'b0, FLD_EPEAK_HI};
         `EC_IDX_PATH_CHANGE_TIMER_A: h = '{1'b0, FLD_TIMER};
         `EC_IDX_PATH_CHANGE_SENS_A:  h = '{1'b0, FLD_SENS};
         `EC_IDX_DT_THRESHOLD_LOW_A:  h = '{1'b0, FLD_DT_LO};
         `EC_IDX_DT_THRESHOLD_HIGH_A: h = '{1'b0, FLD_DT_HI};
         `EC_IDX_SEND_PEAK_LOW_B:     h = '{1'b1, FLD_SPEAK_LO};
         `EC_IDX_SEND_PEAK_HIGH_B:    h = '{1'b1, FLD_SPEAK_HI};
         `EC_IDX_ERROR_PEAK_LOW_B:    h = '{1'b1, FLD_EPEAK_LO};
         `EC_IDX_ERROR_PEAK_HIGH_B:   h = '{1'b1, FLD_EPEAK_HI};
         `EC_IDX_PATH_CHANGE_TIMER_B: h = '{1'b1, FLD_TIMER};
         `EC_IDX_PATH_CHANGE_SENS_B:  h = '{1'b1, FLD_SENS};
         `EC_IDX_DT_THRESHOLD_LOW_B:  h = '{1'b1, FLD_DT_LO};
         `EC_IDX_DT_THRESHOLD_HIGH_B: h = '{1'b1, FLD_DT_HI};
         default:                     h = '{1'b0, FLD_NONE};
      endcase
      return h;
   endfunction

   logic     aligned;
   logic     in_range;
   reg_hit_t hit;
   logic     access;
   logic     wr_en;
   logic     rd_en;
   logic     pready_q;

   // word index decode, upper address bits must be zero
   always_comb begin
      aligned  = (paddr[1:0] == 2'b00);
      in_range = (paddr[AW-1:2] < (AW-2)'(1 << `EC_IDX_W)) || (AW <= 8);
      hit      = decode_idx(paddr[`EC_IDX_W+1:2]);
      if (!aligned || !in_range)
         hit.field = FLD_NONE;
   end

   // one wait state: answer comes in the second access cycle
   assign access = psel && penable && pready_q;
   assign wr_en  = access && pwrite && (hit.field != FLD_NONE);
   assign rd_en  = access && !pwrite;

   // ----------------------------------------------------------------------
   // peak monitors
   // ----------------------------------------------------------------------

   logic [15:0] send_peak [2];
   logic [15:0] err_peak  [2];
   logic [1:0]  send_restart;
   logic [1:0]  err_restart;

   // a read of the high byte starts a new peak window
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         send_restart[c] = rd_en && (hit.field == FLD_SPEAK_HI) && (hit.chan == 1'(c));
         err_restart[c]  = rd_en && (hit.field == FLD_EPEAK_HI) && (hit.chan == 1'(c));
      end
   end

   // send-in peak, canceller a and b
   peak_tracker #(.W(16)) u_send_peak_a (
      .pclk         (pclk),
      .presetn      (presetn),
      .sample_valid (sample_valid),
      .sample       (send_in_a),
      .restart      (send_restart[0]),
      .peak         (send_peak[0])
   );

   peak_tracker #(.W(16)) u_send_peak_b (
      .pclk         (pclk),
      .presetn      (presetn),
      .sample_valid (sample_valid),
      .sample       (send_in_b),
      .restart      (send_restart[1]),
      .peak         (send_peak[1])
   );

   // error peak, canceller a and b
   peak_tracker #(.W(16)) u_err_peak_a (
      .pclk         (pclk),
      .presetn      (presetn),
      .sample_valid (sample_valid),
      .sample       (error_a),
      .restart      (err_restart[0]),
      .peak         (err_peak[0])
   );

   peak_tracker #(.W(16)) u_err_peak_b (
      .pclk         (pclk),
      .presetn      (presetn),
      .sample_valid (sample_valid),
      .sample       (error_b),
      .restart      (err_restart[1]),
      .peak         (err_peak[1])
   );

   // ----------------------------------------------------------------------
   // tuning registers
   // ----------------------------------------------------------------------

   logic [7:0]  timer_q [2];
   logic [7:0]  sens_q  [2];
   logic [15:0] dt_q    [2];

   // per-canceller copies, written only on their own index
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int c = 0; c < 2; c++) begin
            timer_q[c] <= `EC_RST_PATH_CHANGE_TIMER;
            sens_q[c]  <= `EC_RST_PATH_CHANGE_SENS;
            dt_q[c]    <= {`EC_RST_DT_THRESHOLD_HIGH, `EC_RST_DT_THRESHOLD_LOW};
         end
      end else if (wr_en) begin
         unique case (hit.field)
            FLD_TIMER: timer_q[hit.chan]    <= pwdata[7:0];
            FLD_SENS:  sens_q[hit.chan]     <= pwdata[7:0];
            FLD_DT_LO: dt_q[hit.chan][7:0]  <= pwdata[7:0];
            FLD_DT_HI: dt_q[hit.chan][15:8] <= {1'b0, pwdata[`EC_DT_SIGN_BIT-1:0]};
            default:   ;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // path change detectors
   // ----------------------------------------------------------------------

   path_state_t pc_state_q [2];
   logic [7:0]  pc_count_q [2];
   logic [1:0]  pc_pulse_q;
   logic [1:0]  neg_echo_loss_enhancement;

   // negative enhancement deeper than the sensitivity level
   assign neg_echo_loss_enhancement[0] = echo_loss_enhancement_deficit_a > sens_q[0];
   assign neg_echo_loss_enhancement[1] = echo_loss_enhancement_deficit_b > sens_q[1];

   // count ticks of persistent negative enhancement up to the timer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int c = 0; c < 2; c++) begin
            pc_state_q[c] <= PC_WATCH;
            pc_count_q[c] <= 8'h00;
         end
         pc_pulse_q <= 2'b00;
      end else begin
         pc_pulse_q <= 2'b00;
         for (int c = 0; c < 2; c++) begin
            if (measure_tick) begin
               unique case (pc_state_q[c])
                  PC_WATCH, PC_COUNT: begin
                     if (!neg_echo_loss_enhancement[c]) begin
                        pc_state_q[c] <= PC_WATCH;
                        pc_count_q[c] <= 8'h00;
                     end else if (pc_count_q[c] >= timer_q[c]) begin
                        pc_state_q[c] <= PC_DECLARED;
                        pc_pulse_q[c] <= 1'b1;
                     end else begin
                        pc_state_q[c] <= PC_COUNT;
                        pc_count_q[c] <= pc_count_q[c] + 8'h01;
                     end
                  end
                  PC_DECLARED: begin
                     if (!neg_echo_loss_enhancement[c]) begin
                        pc_state_q[c] <= PC_WATCH;
                        pc_count_q[c] <= 8'h00;
                     end
                  end
                  default: begin
                     pc_state_q[c] <= PC_WATCH;
                     pc_count_q[c] <= 8'h00;
                  end
               endcase
            end
         end
      end
   end

   assign path_change_a  = pc_pulse_q[0];
   assign path_change_b  = pc_pulse_q[1];
   assign dt_threshold_a = dt_q[0];
   assign dt_threshold_b = dt_q[1];

   // ----------------------------------------------------------------------
   // apb answer
   // ----------------------------------------------------------------------

   logic [31:0] prdata_q;
   logic        pslverr_q;
   logic [7:0]  rd_byte;

   // read mux, peaks split high byte in second register
   always_comb begin
      unique case (hit.field)
         FLD_SPEAK_LO: rd_byte = send_peak[hit.chan][7:0];
         FLD_SPEAK_HI: rd_byte = send_peak[hit.chan][15:8];
         FLD_EPEAK_LO: rd_byte = err_peak[hit.chan][7:0];
         FLD_EPEAK_HI: rd_byte = err_peak[hit.chan][15:8];
         FLD_TIMER:    rd_byte = timer_q[hit.chan];
         FLD_SENS:     rd_byte = sens_q[hit.chan];
         FLD_DT_LO:    rd_byte = dt_q[hit.chan][7:0];
         FLD_DT_HI:    rd_byte = dt_q[hit.chan][15:8];
         default:      rd_byte = 8'h00;
      endcase
   end

   // ready one cycle after the access phase opens
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         pready_q <= 1'b0;
      else
         pready_q <= psel && penable && !pready_q;
   end

   // read data and error loaded with ready
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (psel && penable && !pready_q) begin
         prdata_q  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
         pslverr_q <= (hit.field == FLD_NONE) ||
                      (pwrite && (hit.field inside {FLD_SPEAK_LO, FLD_SPEAK_HI,
                                                   FLD_EPEAK_LO, FLD_EPEAK_HI}));
      end else begin
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end
   end

   assign pready  = pready_q;
   assign prdata  = prdata_q;
   assign pslverr = pslverr_q;

   // ----------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------

   a_apb_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && !pready_q) |=> pready_q)
      else $error("ready did not follow one wait cycle");

   a_apb_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      pready_q |=> !pready_q)
      else $error("ready held longer than one cycle");

   a_send_peak_high: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && !pready_q && !pwrite && hit.field == FLD_SPEAK_HI && !hit.chan)
      |=> prdata_q[7:0] == $past(send_peak[0][15:8]))
      else $error("send peak high byte misread");

   a_error_peak_low: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && !pready_q && !pwrite && hit.field == FLD_EPEAK_LO && hit.chan)
      |=> prdata_q[7:0] == $past(err_peak[1][7:0]))
      else $error("error peak low byte misread");

   a_send_peak_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (sample_valid && send_in_a == 16'h0100 && !send_restart[0])
      |=> send_peak[0] >= 16'h0100)
      else $error("send peak missed a sample");

   a_dt_max_value: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en && hit.field == FLD_DT_HI |=> !dt_q[$past(hit.chan)][15])
      else $error("double-talk threshold exceeds full scale");

   a_dt_low_write: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && hit.field == FLD_DT_LO && !hit.chan)
      |=> dt_threshold_a[7:0] == $past(pwdata[7:0]) && $stable(dt_threshold_b))
      else $error("double-talk low byte write lost");

   a_chan_indep: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && hit.field == FLD_TIMER && hit.chan) |=> $stable(timer_q[0]))
      else $error("canceller b write touched canceller a");

   a_path_after_timer: assert property (@(posedge pclk) disable iff (!presetn)
      path_change_a |-> $past(measure_tick && neg_echo_loss_enhancement[0] && pc_count_q[0] >= timer_q[0]))
      else $error("path change declared before timer expired");

   a_path_sensitivity: assert property (@(posedge pclk) disable iff (!presetn)
      (measure_tick && echo_loss_enhancement_deficit_a <= sens_q[0]) |=> !path_change_a && pc_count_q[0] == 8'h00)
      else $error("path change counted above sensitivity level");

   a_path_count_step: assert property (@(posedge pclk) disable iff (!presetn)
      (measure_tick && neg_echo_loss_enhancement[0] && pc_state_q[0] != PC_DECLARED && pc_count_q[0] < timer_q[0])
      |=> pc_count_q[0] == $past(pc_count_q[0]) + 8'h01 && !path_change_a)
      else $error("path change timer count did not advance");

endmodule
`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench for the canceller monitor and tuning register group
`timescale 1ns/1ps
`default_nettype none

module tb_top;

   // ----------------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------------
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        sample_valid;
   logic [15:0] send_in_a;
   logic [15:0] send_in_b;
   logic [15:0] error_a;
   logic [15:0] error_b;
   logic        measure_tick;
   logic [7:0]  echo_loss_enhancement_deficit_a;
   logic [7:0]  echo_loss_enhancement_deficit_b;
   logic [15:0] dt_threshold_a;
   logic [15:0] dt_threshold_b;
   logic        path_change_a;
   logic        path_change_b;
   int          n_errors;
   int          compares;
   int          p_cnt [2];
   logic        p_decl [2];
   logic [7:0]  p_tmr [2];
   logic [7:0]  p_sns [2];

   // tuning registers: word index, reset value, writable bits
   localparam logic [5:0] RIDX [8] = '{6'h12, 6'h13, 6'h14, 6'h15, 6'h32, 6'h33, 6'h34, 6'h35};
   localparam logic [7:0] RRST [8] = '{8'h10, 8'h41, 8'h00, 8'h48, 8'h10, 8'h41, 8'h00, 8'h48};
   localparam logic [7:0] RMSK [8] = '{8'hff, 8'hff, 8'hff, 8'h7f, 8'hff, 8'hff, 8'hff, 8'h7f};
   // peak low-byte indices: send a, send b, error a, error b
   localparam logic [5:0] PIDX [4] = '{6'h0e, 6'h2e, 6'h10, 6'h20};

   ec_monitor_regs dut_u (
      .pclk           (pclk),
      .presetn        (presetn),
      .psel           (psel),
      .penable        (penable),
      .pwrite         (pwrite),
      .paddr          (paddr),
      .pwdata         (pwdata),
      .prdata         (prdata),
      .pready         (pready),
      .pslverr        (pslverr),
      .sample_valid   (sample_valid),
      .send_in_a      (send_in_a),
      .send_in_b      (send_in_b),
      .error_a        (error_a),
      .error_b        (error_b),
      .measure_tick   (measure_tick),
      .echo_loss_enhancement_deficit_a (echo_loss_enhancement_deficit_a),
      .echo_loss_enhancement_deficit_b (echo_loss_enhancement_deficit_b),
      .dt_threshold_a (dt_threshold_a),
      .dt_threshold_b (dt_threshold_b),
      .path_change_a  (path_change_a),
      .path_change_b  (path_change_b)
   );

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   // 25 mhz clock
   always #20 pclk = ~pclk;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      $display("counts: compares=%0d errors=%0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // one apb transfer; waits for pready, only the watchdog ends a hang
   task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d,
                      output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // read a word index and compare the error flag, and the data when no error is expected
   task automatic rchk(input logic [5:0] i, input logic [7:0] e, input logic ee);
      logic [31:0] rd;
      logic        err;
      apb({i, 2'b00}, 1'b0, 8'h00, rd, err);
      if (!ee) chk(rd, {24'h000000, e});
      chk({31'h0, err}, {31'h0, ee});
   endtask

   task automatic wchk(input logic [5:0] i, input logic [7:0] d, input logic ee);
      logic [31:0] rd;
      logic        err;
      apb({i, 2'b00}, 1'b1, d, rd, err);
      chk({31'h0, err}, {31'h0, ee});
   endtask

   function automatic logic [15:0] mag(input logic [15:0] x);
      if (x == 16'h8000) return 16'h7fff;
      return x[15] ? (~x + 16'h0001) : x;
   endfunction

   // one evaluation tick; model predicts the pulse of each canceller
   task automatic tick(input logic [7:0] da, input logic [7:0] db);
      logic [1:0] seen;
      logic [1:0] exp;
      logic [7:0] dv [2];
      logic       neg;
      dv[0] = da;
      dv[1] = db;
      @(posedge pclk);
      measure_tick <= 1'b1;
      echo_loss_enhancement_deficit_a <= da;
      echo_loss_enhancement_deficit_b <= db;
      @(posedge pclk);
      measure_tick <= 1'b0;
      seen = 2'b00;
      repeat (2) begin
         @(negedge pclk);
         seen = seen | {path_change_a, path_change_b};
      end
      for (int c = 0; c < 2; c++) begin
         neg = dv[c] > p_sns[c];
         exp[1 - c] = neg && !p_decl[c] && (p_cnt[c] >= p_tmr[c]);
         if (!neg) begin
            p_cnt[c] = 0;
            p_decl[c] = 1'b0;
         end else if (exp[1 - c]) begin
            p_decl[c] = 1'b1;
         end else if (!p_decl[c]) begin
            p_cnt[c]++;
         end
      end
      chk({30'h0, seen}, {30'h0, exp});
   endtask

   // ----------------------------------------------------------------------
   // watchdog
   // ----------------------------------------------------------------------
   initial begin
      repeat (20000) @(posedge pclk);
      n_errors++;
      close_out();
   end

   // ----------------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------------
   initial begin
      logic [7:0]  wv [8];
      logic [15:0] pk [4];
      logic [15:0] sv [4];
      logic [31:0] rd;
      logic        err;
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, sample_valid, measure_tick} = 5'h00;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      {send_in_a, send_in_b, error_a, error_b} = 64'h0;
      echo_loss_enhancement_deficit_a = 8'h00;
      echo_loss_enhancement_deficit_b = 8'h00;
      n_errors = 0;
      compares = 0;
      void'($urandom(32'he3c8));
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;

      // reset values of the tuning registers and threshold outputs
      for (int i = 0; i < 8; i++) rchk(RIDX[i], RRST[i], 1'b0);
      chk({16'h0, dt_threshold_a}, 32'h00004800);
      chk({16'h0, dt_threshold_b}, 32'h00004800);
      $display("test reset values done");

      // random write and read-back, high threshold byte clears bit 7
      for (int i = 0; i < 8; i++) wv[i] = 8'($urandom);
      wv[3] = 8'hff;
      for (int i = 0; i < 8; i++) wchk(RIDX[i], wv[i], 1'b0);
      for (int i = 0; i < 8; i++) rchk(RIDX[i], wv[i] & RMSK[i], 1'b0);
      chk({16'h0, dt_threshold_a}, {16'h0, wv[3] & 8'h7f, wv[2]});
      chk({16'h0, dt_threshold_b}, {16'h0, wv[7] & 8'h7f, wv[6]});
      $display("test write read-back done");

      // refused accesses: peak registers read-only, unmapped and misaligned
      wchk(6'h10, 8'h55, 1'b1);
      wchk(6'h21, 8'haa, 1'b1);
      apb(8'h00, 1'b0, 8'h00, rd, err);
      chk({31'h0, err}, 32'h1);
      apb(8'h49, 1'b0, 8'h00, rd, err);
      chk({31'h0, err}, 32'h1);
      $display("test refusals done");

      // peak capture on random samples with corner values among them
      for (int j = 0; j < 4; j++) pk[j] = 16'h0000;
      for (int k = 0; k < 24; k++) begin
         for (int j = 0; j < 4; j++) sv[j] = 16'($urandom);
         if (k == 3) sv[0] = 16'h0100;
         if (k == 7) sv = '{16'h7fff, 16'hffff, 16'h8000, 16'h8001};
         for (int j = 0; j < 4; j++) if (mag(sv[j]) > pk[j]) pk[j] = mag(sv[j]);
         @(posedge pclk);
         sample_valid <= 1'b1;
         {send_in_a, send_in_b, error_a, error_b} <= {sv[0], sv[1], sv[2], sv[3]};
      end
      @(posedge pclk);
      sample_valid <= 1'b0;
      {send_in_a, send_in_b, error_a, error_b} <= {4{16'h7ffe}};
      for (int j = 0; j < 4; j++) begin
         rchk(PIDX[j], pk[j][7:0], 1'b0);
         rchk(PIDX[j] + 6'h01, pk[j][15:8], 1'b0);
      end
      $display("test peak monitors done");

      // path change: timer 2 on a, timer 5 on b, shared sensitivity first
      wchk(6'h12, 8'h02, 1'b0);
      wchk(6'h32, 8'h05, 1'b0);
      wchk(6'h13, 8'h20, 1'b0);
      wchk(6'h33, 8'h20, 1'b0);
      p_tmr = '{8'h02, 8'h05};
      p_sns = '{8'h20, 8'h20};
      p_cnt = '{0, 0};
      p_decl = '{1'b0, 1'b0};
      repeat (8) tick(8'h21, 8'h21);
      tick(8'h20, 8'h00);
      wchk(6'h33, 8'h80, 1'b0);
      p_sns[1] = 8'h80;
      repeat (4) tick(8'h50, 8'h50);
      for (int k = 0; k < 30; k++) tick(8'h1e + 8'($urandom % 5), 8'h7e + 8'($urandom % 5));
      $display("test path change done");
      close_out();
   end

endmodule
`default_nettype wire
